// ---- verilog/uhrp_dev.sv ----
// Contract
// - Sixteen registers reachable only through port
// - Control 00, pointer 01, length 02
// - 03 writes token/endpoint, reads packet status
// - 04 writes device address, reads count
// - Control 05, enable 06, status 0D, revision 0E
// - Every data access advances address counter
// - Index low loads counter, high writes data
// - Reads also increment after each access
// - Any of 127 addresses, 16 endpoints
// - Processor generates start-of-frame and frame number
// - Processor issues frame token every 1 ms
// - Frame packet holds PID, number, CRC5
// - Processor precomputes next frame number, CRC
// - Processor answers interrupt within 1.5 us
// - Host wakes peripheral after 3 ms silence
// - Address write index 0, data index 1
// - Address latch strobe loads counter from bus
// - Writing interrupt status clears interrupt output
// - Sixteen register bytes, 240 buffer bytes
//
// Strobed register access was decided locally.
module uhrp_dev #(
  parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // Processor port
  uhrp_if.dev             bus,
  // Serial engine: register view
  output logic [7:0]      o_xfer_ctrl,
  output logic [7:0]      o_buf_ptr,
  output logic [7:0]      o_xfer_len,
  output logic [3:0]      o_pid_code,
  output logic [3:0]      o_endpoint,
  output logic [6:0]      o_dev_addr,
  output logic [7:0]      o_gen_ctrl,
  input  wire logic       i_arm_clr,
  input  wire logic [7:0] i_pkt_status,
  input  wire logic [7:0] i_xfer_count,
  input  wire logic [7:0] i_irq_event,
  // Serial engine: buffer port
  input  wire logic [7:0] i_eng_addr,
  input  wire logic       i_eng_we,
  input  wire logic [7:0] i_eng_wdata,
  output logic [7:0]      o_eng_rdata
);

  localparam int NUM_CTL = uhrp_pkg::NUM_CTL;

  logic [7:0] addr_cnt_ff;
  logic [7:0] rd_value;
  logic [7:0] wdata_ff;
  logic       idx_ff;
  logic       wr_prev_ff;
  logic       rd_prev_ff;
  logic [7:0] rdata_ff;
  logic [7:0] ctl_ff [NUM_CTL];
  logic [7:0] irq_stat_ff;
  logic [7:0] eng_rdata_ff;
  logic [7:0] buf_mem [int'(uhrp_pkg::OFS_BUF_FIRST):int'(uhrp_pkg::OFS_BUF_LAST)];

  // Pin decode
  wire        wr_act    = !bus.chip_select_n && !bus.write_strobe_n;
  wire        rd_act    = !bus.chip_select_n && !bus.read_strobe_n;
  wire        wr_end    = wr_prev_ff && !wr_act;
  wire        rd_start  = rd_act && !rd_prev_ff;
  wire        rd_end    = rd_prev_ff && !rd_act;
  wire        ale_load  = bus.addr_latch;
  wire        addr_wr   = wr_end && !idx_ff;
  wire        data_wr   = wr_end && idx_ff;
  wire        in_buf    = addr_cnt_ff >= uhrp_pkg::OFS_BUF_FIRST;
  wire        buf_wr    = data_wr && in_buf;
  wire        eng_wr_ok = i_eng_we && (i_eng_addr >= uhrp_pkg::OFS_BUF_FIRST);
  wire [7:0]  nxt_addr  = addr_cnt_ff + 8'h01;
  wire [7:0]  irq_clr   = (data_wr && addr_cnt_ff == uhrp_pkg::OFS_IRQ_STAT) ? wdata_ff
                                                                             : 8'h00;
  wire [7:0]  nxt_irq   = (irq_stat_ff & ~irq_clr) | i_irq_event;

  function automatic logic ctl_hit(input logic [7:0] a, input logic [7:0] ofs);
    ctl_hit = data_wr && (a == ofs);
  endfunction

  // Register and buffer read selection
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= uhrp_pkg::OFS_BUF_FIRST) begin
      v = buf_mem[a];
    end else begin
      unique case (a)
        uhrp_pkg::OFS_XFER_CTRL,
        uhrp_pkg::OFS_BUF_PTR,
        uhrp_pkg::OFS_XFER_LEN,
        uhrp_pkg::OFS_GEN_CTRL,
        uhrp_pkg::OFS_IRQ_EN:      v = ctl_ff[a[2:0]];
        uhrp_pkg::OFS_TOKEN_STAT:  v = i_pkt_status;
        uhrp_pkg::OFS_DADDR_COUNT: v = i_xfer_count;
        uhrp_pkg::OFS_IRQ_STAT:    v = irq_stat_ff;
        uhrp_pkg::OFS_REVISION:    v = REVISION;
        default:                   v = 8'h00;          // Reserved slots read zero
      endcase
    end
    reg_read = v;
  endfunction

  // A process, not a continuous assignment: the function reads RAM and registers,
  // which a continuous assignment would not be sensitive to
  always_comb begin
    rd_value = reg_read(addr_cnt_ff);
  end

  // Pin sampling: data is captured while the strobe is active and used at its end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_prev_ff <= 1'b0;
      rd_prev_ff <= 1'b0;
      wdata_ff   <= uhrp_pkg::REG_RST;
      idx_ff     <= 1'b0;
    end else begin
      wr_prev_ff <= wr_act;
      rd_prev_ff <= rd_act;
      if (wr_act) begin
        wdata_ff <= bus.bus_data;
        idx_ff   <= bus.index_select;
      end
    end
  end

  // Address counter
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_cnt_ff <= uhrp_pkg::ADDR_RST;
    // Multiplexed-bus loads win over indexed loads; the host never mixes them
    end else if (ale_load) begin
      addr_cnt_ff <= bus.bus_data;
    end else if (addr_wr) begin
      addr_cnt_ff <= wdata_ff;
    end else if (data_wr || rd_end) begin
      addr_cnt_ff <= nxt_addr;
    end
  end

  // Read data is frozen at the start of the strobe so the pins stay stable
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_ff <= uhrp_pkg::REG_RST;
    end else if (rd_start) begin
      rdata_ff <= rd_value;
    end
  end

  // Control registers; the engine clearing Arm loses to a processor write
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_CTL; i++) begin
        ctl_ff[i] <= uhrp_pkg::REG_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CTL; i++) begin
        if (ctl_hit(addr_cnt_ff, 8'(i))) begin
          ctl_ff[i] <= wdata_ff;
        end else if (i == 0 && i_arm_clr) begin
          ctl_ff[i][uhrp_pkg::ARM_BIT] <= 1'b0;
        end
      end
    end
  end

  // Interrupt status: new events win over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_stat_ff <= uhrp_pkg::REG_RST;
    end else begin
      irq_stat_ff <= nxt_irq;
    end
  end

  // Packet buffer; a processor write wins a collision with the engine
  always_ff @(posedge i_clk) begin
    if (buf_wr) begin
      buf_mem[addr_cnt_ff] <= wdata_ff;
    end else if (eng_wr_ok) begin
      buf_mem[i_eng_addr] <= i_eng_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      eng_rdata_ff <= uhrp_pkg::REG_RST;
    end else begin
      // Registers live in flops, so the engine sees zero below the buffer
      eng_rdata_ff <= (i_eng_addr >= uhrp_pkg::OFS_BUF_FIRST) ? buf_mem[i_eng_addr] : 8'h00;
    end
  end

  // Outputs
  assign bus.dev_d    = rdata_ff;
  assign bus.dev_d_oe = rd_act && rd_prev_ff;
  assign bus.irq_out  = |(irq_stat_ff & ctl_ff[uhrp_pkg::OFS_IRQ_EN[2:0]]);

  assign o_xfer_ctrl  = ctl_ff[uhrp_pkg::OFS_XFER_CTRL[2:0]];
  assign o_buf_ptr    = ctl_ff[uhrp_pkg::OFS_BUF_PTR[2:0]];
  assign o_xfer_len   = ctl_ff[uhrp_pkg::OFS_XFER_LEN[2:0]];
  assign o_pid_code   = ctl_ff[uhrp_pkg::OFS_TOKEN_STAT[2:0]][7:uhrp_pkg::PID_LSB];
  assign o_endpoint   = ctl_ff[uhrp_pkg::OFS_TOKEN_STAT[2:0]][uhrp_pkg::EP_MSB:0];
  assign o_dev_addr   = ctl_ff[uhrp_pkg::OFS_DADDR_COUNT[2:0]][uhrp_pkg::DADDR_MSB:0];
  assign o_gen_ctrl   = ctl_ff[uhrp_pkg::OFS_GEN_CTRL[2:0]];
  assign o_eng_rdata  = eng_rdata_ff;

endmodule // uhrp_dev

// ---- verilog/uhrp_pkg.sv ----
package uhrp_pkg;

  // Device register map
  localparam logic [7:0] OFS_XFER_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BUF_PTR     = 8'h01;
  localparam logic [7:0] OFS_XFER_LEN    = 8'h02;
  localparam logic [7:0] OFS_TOKEN_STAT  = 8'h03;
  localparam logic [7:0] OFS_DADDR_COUNT = 8'h04;
  localparam logic [7:0] OFS_GEN_CTRL    = 8'h05;
  localparam logic [7:0] OFS_IRQ_EN      = 8'h06;
  localparam logic [7:0] OFS_RSVD        = 8'h07;
  localparam logic [7:0] OFS_IRQ_STAT    = 8'h0d;
  localparam logic [7:0] OFS_REVISION    = 8'h0e;
  localparam logic [7:0] OFS_BUF_FIRST   = 8'h10;
  localparam logic [7:0] OFS_BUF_LAST    = 8'hff;
  localparam int         NUM_CTL         = 7;

  // Field positions
  localparam int         ARM_BIT         = 0;
  localparam int         EP_MSB          = 3;
  localparam int         PID_LSB         = 4;
  localparam int         DADDR_MSB       = 6;

  // Reset values
  localparam logic [7:0] REG_RST         = 8'h00;
  localparam logic [7:0] ADDR_RST        = 8'h00;
  localparam logic [7:0] BUS_IDLE        = 8'hff;

  // Host controller register map
  localparam logic [3:0] H_INDEX         = 4'h0;
  localparam logic [3:0] H_DATA          = 4'h1;
  localparam logic [3:0] H_READ_GO       = 4'h2;
  localparam logic [3:0] H_STATUS        = 4'h3;
  localparam logic [3:0] H_FRAME_LO      = 4'h4;
  localparam logic [3:0] H_FRAME_HI      = 4'h5;
  localparam int         ST_BUSY         = 0;
  localparam int         ST_IRQ          = 1;
  localparam int         ST_SOF_DUE      = 2;

  // Timing
  localparam int         CLK_NS          = 40;
  localparam int         STROBE_NS       = 80;
  localparam int         SOF_PERIOD_NS   = 1000000;
  localparam int         STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int         SOF_PERIOD_CYC  = SOF_PERIOD_NS / CLK_NS;
  localparam logic [1:0] STROBE_LAST     = 2'(STROBE_CYC - 1);
  localparam logic [10:0] FRAME_RST      = 11'h000;
  localparam logic [4:0] CRC5_INIT       = 5'h1f;
  localparam logic [4:0] CRC5_POLY       = 5'h05;

  typedef enum logic [1:0] {
    HS_IDLE   = 2'b00,
    HS_SETUP  = 2'b01,
    HS_STROBE = 2'b11,
    HS_END    = 2'b10
  } uhrp_hstate_e;

endpackage

// ---- verilog/uhrp_if.sv ----
interface uhrp_if;
  logic       chip_select_n;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic       index_select;
  logic       addr_latch;
  logic [7:0] host_d;
  logic       host_d_oe;
  logic [7:0] dev_d;
  logic       dev_d_oe;
  logic       irq_out;
  logic [7:0] bus_data;

  // Undriven bus floats high through the board pull-ups
  assign bus_data = host_d_oe ? host_d : (dev_d_oe ? dev_d : uhrp_pkg::BUS_IDLE);

  modport dev (
    input  chip_select_n, write_strobe_n, read_strobe_n, index_select, addr_latch, bus_data,
    output dev_d, dev_d_oe, irq_out
  );
  modport host (
    output chip_select_n, write_strobe_n, read_strobe_n, index_select, addr_latch,
    output host_d, host_d_oe,
    input  bus_data, irq_out
  );
endinterface

// ---- verilog/uhrp_host.sv ----
module uhrp_host #(
  parameter int SOF_PERIOD = uhrp_pkg::SOF_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // Software port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  // Events
  output logic            o_irq,
  output logic            o_sof_tick,
  // Processor port
  uhrp_if.host            bus
);

  uhrp_pkg::uhrp_hstate_e state_ff;
  uhrp_pkg::uhrp_hstate_e nxt_state;
  logic [1:0]  strb_cnt_ff;
  logic        is_read_ff;
  logic        idx_ff;
  logic [7:0]  dout_ff;
  logic [7:0]  last_rd_ff;
  logic [7:0]  rdata_ff;
  logic [15:0] timer_ff;
  logic [10:0] frame_ff;
  logic [4:0]  crc_ff;
  logic        sof_due_ff;

  // USB CRC5 over an 11-bit frame number, least significant bit first
  function automatic logic [4:0] crc5(input logic [10:0] d);
    logic [4:0] c;
    logic       fb;
    c = uhrp_pkg::CRC5_INIT;
    for (int i = 0; i < 11; i++) begin
      fb = d[i] ^ c[4];
      c  = {c[3:0], 1'b0} ^ (fb ? uhrp_pkg::CRC5_POLY : 5'h00);
    end
    crc5 = ~c;
  endfunction

  // Worked out at elaboration so the reset branch loads a plain constant
  localparam logic [4:0] CRC_RST = crc5(uhrp_pkg::FRAME_RST);

  wire        idle     = state_ff == uhrp_pkg::HS_IDLE;
  wire        go_index = idle && i_wr && i_addr == uhrp_pkg::H_INDEX;
  wire        go_data  = idle && i_wr && i_addr == uhrp_pkg::H_DATA;
  wire        go_read  = idle && i_wr && i_addr == uhrp_pkg::H_READ_GO;
  wire        go_any   = go_index || go_data || go_read;
  wire        strb_on  = state_ff == uhrp_pkg::HS_STROBE;
  wire        strb_fin = strb_on && strb_cnt_ff == uhrp_pkg::STROBE_LAST;
  wire        tick     = timer_ff == 16'(SOF_PERIOD - 1);
  wire        due_clr  = i_wr && i_addr == uhrp_pkg::H_STATUS && i_wdata[uhrp_pkg::ST_SOF_DUE];
  wire [10:0] nxt_frm  = frame_ff + 11'h001;
  wire [7:0]  status_v = {5'h00, sof_due_ff, bus.irq_out, !idle};
  wire [7:0]  rd_sel   = (i_addr == uhrp_pkg::H_DATA)     ? last_rd_ff :
                         (i_addr == uhrp_pkg::H_STATUS)   ? status_v :
                         (i_addr == uhrp_pkg::H_FRAME_LO) ? frame_ff[7:0] :
                         (i_addr == uhrp_pkg::H_FRAME_HI) ? {crc_ff, frame_ff[10:8]} : 8'h00;

  // Cycle sequencer: setup, strobe for a fixed width, release
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      uhrp_pkg::HS_IDLE:   if (go_any) nxt_state = uhrp_pkg::HS_SETUP;
      uhrp_pkg::HS_SETUP:  nxt_state = uhrp_pkg::HS_STROBE;
      uhrp_pkg::HS_STROBE: if (strb_fin) nxt_state = uhrp_pkg::HS_END;
      uhrp_pkg::HS_END:    nxt_state = uhrp_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff    <= uhrp_pkg::HS_IDLE;
      strb_cnt_ff <= 2'b00;
      is_read_ff  <= 1'b0;
      idx_ff      <= 1'b0;
      dout_ff     <= uhrp_pkg::REG_RST;
      last_rd_ff  <= uhrp_pkg::REG_RST;
    end else begin
      state_ff    <= nxt_state;
      strb_cnt_ff <= strb_on ? strb_cnt_ff + 2'b01 : 2'b00;
      if (go_any) begin
        is_read_ff <= go_read;
        idx_ff     <= !go_index;
        dout_ff    <= i_wdata;
      end
      if (strb_fin && is_read_ff) begin
        last_rd_ff <= bus.bus_data;
      end
    end
  end

  // Frame timer with the next frame number and CRC kept ready
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      timer_ff   <= 16'h0000;
      frame_ff   <= uhrp_pkg::FRAME_RST;
      crc_ff     <= CRC_RST;
      sof_due_ff <= 1'b0;
      rdata_ff   <= uhrp_pkg::REG_RST;
    end else begin
      timer_ff <= tick ? 16'h0000 : timer_ff + 16'h0001;
      if (tick) begin
        frame_ff <= nxt_frm;
        crc_ff   <= crc5(nxt_frm);
      end
      sof_due_ff <= tick || (sof_due_ff && !due_clr);
      rdata_ff   <= i_rd ? rd_sel : rdata_ff;
    end
  end

  assign o_rdata            = rdata_ff;
  assign o_irq              = bus.irq_out;
  assign o_sof_tick         = tick;
  assign bus.chip_select_n  = !(state_ff != uhrp_pkg::HS_IDLE);
  assign bus.write_strobe_n = !(strb_on && !is_read_ff);
  assign bus.read_strobe_n  = !(strb_on && is_read_ff);
  assign bus.index_select   = idx_ff;
  assign bus.addr_latch     = 1'b0;
  assign bus.host_d         = dout_ff;
  assign bus.host_d_oe      = !is_read_ff && !idle;

endmodule // uhrp_host

// ---- testbench/uhrp_asserts.sv ----
module uhrp_asserts (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Processor port signals
  input  wire logic chip_select_n,
  input  wire logic write_strobe_n,
  input  wire logic read_strobe_n,
  input  wire logic index_select,
  input  wire logic addr_latch,
  input  wire logic host_d_oe,
  input  wire logic dev_d_oe,
  input  wire logic irq_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Two strobe cycles, one release cycle with select held, then deselect
  sequence s_wr_pulse;
    !write_strobe_n [*2] ##1 (write_strobe_n && !chip_select_n) ##1 chip_select_n;
  endsequence
  sequence s_rd_pulse;
    !read_strobe_n [*2] ##1 (read_strobe_n && !chip_select_n) ##1 chip_select_n;
  endsequence

  AST_WR_PULSE: assert property ($fell(write_strobe_n) |-> s_wr_pulse)
    else $error("write strobe shape wrong");
  AST_RD_PULSE: assert property ($fell(read_strobe_n) |-> s_rd_pulse)
    else $error("read strobe shape wrong");
  AST_CYCLE_LEN: assert property ($fell(chip_select_n) |-> !chip_select_n [*4] ##1 chip_select_n)
    else $error("bus cycle length wrong");
  AST_SETUP: assert property ($fell(chip_select_n) |->
      (write_strobe_n && read_strobe_n) ##1 (!write_strobe_n || !read_strobe_n))
    else $error("no setup cycle before strobe");
  AST_STROBE_SEL: assert property ((!write_strobe_n || !read_strobe_n) |->
      (!chip_select_n && (write_strobe_n || read_strobe_n)))
    else $error("strobe without select or both strobes");
  AST_INDEX_STABLE: assert property ((!chip_select_n && !$past(chip_select_n)) |->
      $stable(index_select))
    else $error("index select moved in a cycle");
  AST_WR_DRIVE: assert property (!write_strobe_n |-> (host_d_oe && !dev_d_oe))
    else $error("bus not driven by host in write");
  AST_DEV_DRIVE: assert property ($fell(read_strobe_n) |-> ##1 (dev_d_oe && !host_d_oe))
    else $error("device does not drive read data");
  AST_DEV_OE_CS: assert property (dev_d_oe |-> (!chip_select_n && write_strobe_n))
    else $error("device drives bus outside read");
  AST_ALE_IDLE: assert property (!addr_latch)
    else $error("address latch used");
  AST_IRQ_CLEAR: assert property ($fell(irq_out) |->
      (!$past(write_strobe_n, 2) || !$past(write_strobe_n, 3)))
    else $error("interrupt dropped without a write");
endmodule // uhrp_asserts

// ---- testbench/uhrp_test.sv ----
module uhrp_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SOF_SIM = 50;
  logic       i_clk        = 1'b0;
  logic       i_sys_rst    = 1'b1;
  logic [3:0] i_addr       = 4'h0;
  logic [7:0] i_wdata      = 8'h00;
  logic       i_wr         = 1'b0;
  logic       i_rd         = 1'b0;
  logic       i_arm_clr    = 1'b0;
  logic [7:0] i_irq_event  = 8'h00;
  logic [7:0] i_eng_addr   = 8'h00;
  logic       i_eng_we     = 1'b0;
  logic [7:0] i_eng_wdata  = 8'h00;
  logic [7:0] o_rdata, o_xfer_ctrl, o_buf_ptr, o_xfer_len, o_gen_ctrl, o_eng_rdata, v;
  logic [3:0] o_pid_code, o_endpoint;
  logic [6:0] o_dev_addr;
  logic       o_irq, o_sof_tick;
  int         err_total = 0;
  int         cmp_count = 0;
  int         cyc_cnt   = 0;
  int         k;
  // Rows: offset, written byte, byte read back
  logic [23:0] rows [12] = '{24'h00a5a5, 24'h013c3c, 24'h024040, 24'h03e15a, 24'h047f3c,
    24'h058181, 24'h060000, 24'h07ff00, 24'h0e1101, 24'h0f2200, 24'h105555, 24'hff9999};

  uhrp_if u_uhrp_if ();
  uhrp_host #(.SOF_PERIOD(SOF_SIM)) u_uhrp_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_sof_tick(o_sof_tick), .bus(u_uhrp_if));
  uhrp_dev u_uhrp_dev (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(u_uhrp_if),
    .o_xfer_ctrl(o_xfer_ctrl), .o_buf_ptr(o_buf_ptr), .o_xfer_len(o_xfer_len),
    .o_pid_code(o_pid_code), .o_endpoint(o_endpoint), .o_dev_addr(o_dev_addr),
    .o_gen_ctrl(o_gen_ctrl), .i_arm_clr(i_arm_clr), .i_pkt_status(8'h5a),
    .i_xfer_count(8'h3c), .i_irq_event(i_irq_event), .i_eng_addr(i_eng_addr),
    .i_eng_we(i_eng_we), .i_eng_wdata(i_eng_wdata), .o_eng_rdata(o_eng_rdata));
  uhrp_asserts u_uhrp_asserts (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .chip_select_n(u_uhrp_if.chip_select_n), .write_strobe_n(u_uhrp_if.write_strobe_n),
    .read_strobe_n(u_uhrp_if.read_strobe_n), .index_select(u_uhrp_if.index_select),
    .addr_latch(u_uhrp_if.addr_latch), .host_d_oe(u_uhrp_if.host_d_oe),
    .dev_d_oe(u_uhrp_if.dev_d_oe), .irq_out(u_uhrp_if.irq_out));

  always #20 i_clk = ~i_clk;

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Ceiling is about thirty times the expected run length
  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  // One host bus cycle; busy clears four cycles after it is taken
  task automatic hwr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (5) @(posedge i_clk);
  endtask

  task automatic hrd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    hwr(uhrp_pkg::H_INDEX, a);
    hwr(uhrp_pkg::H_DATA, d);
  endtask

  task automatic drd(output logic [7:0] d);
    hwr(uhrp_pkg::H_READ_GO, 8'h00);
    hrd(uhrp_pkg::H_DATA, d);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1 chk(o_xfer_ctrl, 8'h00);
    chk({7'h00, o_irq}, 8'h00);
    done("reset");
    foreach (rows[i]) begin
      dwr(rows[i][23:16], rows[i][15:8]);
      hwr(uhrp_pkg::H_INDEX, rows[i][23:16]);
      drd(v);
      chk(v, rows[i][7:0]);
    end
    chk({o_pid_code, o_endpoint}, 8'he1);
    chk({1'b0, o_dev_addr}, 8'h7f);
    chk(o_xfer_len, 8'h40);
    chk(o_gen_ctrl, 8'h81);
    done("map");
    // Crossing the top of memory shows the counter wrap into register 00
    hwr(uhrp_pkg::H_INDEX, 8'hfe);
    for (int i = 1; i < 4; i++) hwr(uhrp_pkg::H_DATA, 8'(8'h11 * i));
    hwr(uhrp_pkg::H_INDEX, 8'hfe);
    for (int i = 1; i < 4; i++) begin
      drd(v);
      chk(v, 8'(8'h11 * i));
    end
    chk(o_xfer_ctrl, 8'h33);
    hwr(uhrp_pkg::H_INDEX, 8'h10);
    hwr(uhrp_pkg::H_DATA, 8'h55);
    hwr(uhrp_pkg::H_DATA, 8'haa);
    hwr(uhrp_pkg::H_DATA, 8'hbb);
    @(posedge i_clk);
    i_eng_addr <= 8'h12;
    @(posedge i_clk);
    #1 chk(o_eng_rdata, 8'hbb);
    @(posedge i_clk);
    i_eng_addr <= 8'h20;
    i_eng_we <= 1'b1;
    i_eng_wdata <= 8'hc3;
    @(posedge i_clk);
    i_eng_we <= 1'b0;
    hwr(uhrp_pkg::H_INDEX, 8'h20);
    drd(v);
    chk(v, 8'hc3);
    done("increment");
    @(posedge i_clk);
    i_irq_event <= 8'h01;
    @(posedge i_clk);
    i_irq_event <= 8'h00;
    repeat (3) @(posedge i_clk);
    #1 chk({7'h00, o_irq}, 8'h00);
    dwr(uhrp_pkg::OFS_IRQ_EN, 8'h01);
    chk({7'h00, o_irq}, 8'h01);
    hrd(uhrp_pkg::H_STATUS, v);
    chk({7'h00, v[uhrp_pkg::ST_IRQ]}, 8'h01);
    dwr(uhrp_pkg::OFS_IRQ_STAT, 8'h01);
    chk({7'h00, o_irq}, 8'h00);
    dwr(uhrp_pkg::OFS_XFER_CTRL, 8'h01);
    @(posedge i_clk);
    i_arm_clr <= 1'b1;
    @(posedge i_clk);
    i_arm_clr <= 1'b0;
    @(posedge i_clk);
    #1 chk(o_xfer_ctrl, 8'h00);
    done("interrupt");
    repeat (2) begin
      k = 0;
      do begin
        @(posedge i_clk);
        #1;
        k++;
      end while (o_sof_tick !== 1'b1 && k < 200);
    end
    chk(8'(k), 8'(SOF_SIM));
    hrd(uhrp_pkg::H_STATUS, v);
    chk({7'h00, v[uhrp_pkg::ST_SOF_DUE]}, 8'h01);
    hwr(uhrp_pkg::H_STATUS, 8'h04);
    hrd(uhrp_pkg::H_STATUS, v);
    chk({7'h00, v[uhrp_pkg::ST_SOF_DUE]}, 8'h00);
    done("frame");
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1 chk(o_buf_ptr, 8'h00);
    hrd(uhrp_pkg::H_FRAME_LO, v);
    chk(v, 8'h00);
    hrd(uhrp_pkg::H_FRAME_HI, v);
    chk(v, 8'h40);
    hwr(uhrp_pkg::H_INDEX, uhrp_pkg::OFS_BUF_PTR);
    drd(v);
    chk(v, 8'h00);
    done("second reset");
    finish_test();
  end
endmodule // uhrp_test
